//--- hw/dm_minute_tick.sv
// Minute prescaler with restart for the screen saver timing
`default_nettype none
module dm_minute_tick #(
  parameter longint unsigned TICK_CYCLES = dm_pkg::MINUTE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control and tick
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic tick_ff;
  wire at_last = (cnt_ff == LAST);

  initial begin
    if (TICK_CYCLES < 2) $error("dm_minute_tick: TICK_CYCLES must be at least 2");
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= (restart || at_last) ? '0 : cnt_ff + 1'b1;
      tick_ff <= at_last && !restart;
    end
  end

  assign tick = tick_ff;
endmodule : dm_minute_tick
`default_nettype wire

//--- hw/dm_pkg.sv
// Shared constants for the display monitor system-information block
`default_nettype none
package dm_pkg;
  // Byte addresses of the software-visible registers
  localparam logic [7:0] ADDR_WORD_BASE = 8'h00;
  localparam logic [7:0] ADDR_BIT_BASE = 8'h04;
  localparam logic [7:0] ADDR_DEV_TYPE = 8'h08;
  localparam logic [7:0] ADDR_DEV_NUM = 8'h0C;
  localparam logic [7:0] ADDR_SAVER_TIME = 8'h10;
  localparam logic [7:0] ADDR_PROTECT_DEV = 8'h14;
  localparam logic [7:0] ADDR_SPARE_WORD = 8'h18;
  localparam logic [7:0] ADDR_CTL_BITS = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // Base pointer value meaning that no block is assigned
  localparam logic [15:0] BASE_NONE = 16'hFFFF;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Bit offsets inside the bit block
  localparam int BIT_REQ = 0;
  localparam int BIT_DONE = 1;
  localparam int BIT_INHIBIT = 2;
  localparam int BIT_ESC = 4;
  localparam int BIT_MINUS = 5;
  localparam int BIT_PLUS = 6;
  localparam int BIT_OK = 7;
  localparam int BIT_HEX = 8;
  localparam int BIT_SHOWN = 9;
  localparam int BIT_BLOCK_LEN = 15;

  // Status register field positions
  localparam int ST_TYPE_LSB = 0;
  localparam int ST_SCREEN_LSB = 4;
  localparam int ST_FUNC_EN = 6;
  localparam int ST_NUM_LSB = 16;

  // Device type codes
  localparam logic [3:0] TYPE_MIN = 4'h1;
  localparam logic [3:0] TYPE_MAX = 4'hA;
  localparam logic [3:0] TYPE_NONE = 4'h0;

  // Highest device number per type code 1..10; plain defaults, tune per product
  localparam logic [15:0] DEV_MAX [1:10] = '{16'h00FF, 16'h00FF, 16'h0FFF, 16'h0FFF,
    16'h00FF, 16'h00FF, 16'h1FFF, 16'h1FFE, 16'h7FFF, 16'h7FFE};

  // Timing
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned MINUTE_CYCLES = CLK_HZ * MINUTE_S;
  localparam logic [15:0] SAVER_DEFAULT_MIN = 16'h000A;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {SCR_TOP, SCR_SPEC, SCR_MENU, SCR_SAVER} dm_screen_t;
endpackage : dm_pkg
`default_nettype wire

//--- hw/dm_sysinfo.sv
// System-information register bank and specified-device monitor control
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module dm_sysinfo #(
  parameter int ADDR_W = 8,
  parameter longint unsigned MINUTE_CYCLES = dm_pkg::MINUTE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Panel buttons and editor, asynchronous
  input wire logic btn_esc,
  input wire logic btn_minus,
  input wire logic btn_plus,
  input wire logic btn_ok,
  input wire logic test_done,
  // Screen control
  output logic [1:0] screen_sel,
  output logic [3:0] shown_type,
  output logic [15:0] shown_num,
  output logic edit_enable,
  output logic hex_format,
  output logic spec_marker,
  output logic saver_on
);
  initial begin
    if (ADDR_W < 6) $error("dm_sysinfo: ADDR_W too small for the register map");
  end

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    lane_merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction : lane_merge

  // Address match on the low byte of a word address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
    hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(reg_addr));
  endfunction : hit

  // Input synchronisers: esc, minus, plus, ok, test_done
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] prev_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= {test_done, btn_ok, btn_plus, btn_minus, btn_esc};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end
  wire [4:0] rise = sync2_ff & ~prev_ff;
  wire esc_hit = rise[0];
  wire ok_hit = rise[3];
  wire done_hit = rise[4];
  wire any_press = |rise[3:0];

  // Stored registers
  logic [15:0] word_base_ff;
  logic [15:0] bit_base_ff;
  logic [15:0] dev_type_ff;
  logic [15:0] dev_num_ff;
  logic [15:0] saver_time_ff;
  logic [15:0] protect_dev_ff;
  logic [15:0] spare_word_ff;
  logic req_ff;
  logic done_ff;
  logic inhibit_ff;
  logic hex_ff;
  logic req_prev_ff;
  logic [3:0] btn_mirror_ff;
  logic shown_ff;
  dm_pkg::dm_screen_t scr_ff;
  dm_pkg::dm_screen_t nxt_scr;

  // Write channel
  logic aw_full_ff;
  logic w_full_ff;
  logic [ADDR_W-1:0] wa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  wire aw_take = s_axi_awvalid && awready_ff;
  wire w_take = s_axi_wvalid && wready_ff;
  wire wr_do = aw_full_ff && w_full_ff;
  wire nxt_aw_full = (aw_full_ff && !wr_do) || aw_take;
  wire nxt_w_full = (w_full_ff && !wr_do) || w_take;
  wire nxt_bvalid = wr_do || (bvalid_ff && !s_axi_bready);

  wire wr_word_base = wr_do && hit(wa_ff, dm_pkg::ADDR_WORD_BASE);
  wire wr_bit_base = wr_do && hit(wa_ff, dm_pkg::ADDR_BIT_BASE);
  wire wr_type = wr_do && hit(wa_ff, dm_pkg::ADDR_DEV_TYPE);
  wire wr_num = wr_do && hit(wa_ff, dm_pkg::ADDR_DEV_NUM);
  wire wr_saver = wr_do && hit(wa_ff, dm_pkg::ADDR_SAVER_TIME);
  wire wr_protect = wr_do && hit(wa_ff, dm_pkg::ADDR_PROTECT_DEV);
  wire wr_spare = wr_do && hit(wa_ff, dm_pkg::ADDR_SPARE_WORD);
  wire wr_bits = wr_do && hit(wa_ff, dm_pkg::ADDR_CTL_BITS);
  wire wr_status = wr_do && hit(wa_ff, dm_pkg::ADDR_STATUS);
  wire wr_known = wr_word_base || wr_bit_base || wr_type || wr_num || wr_saver ||
                  wr_protect || wr_spare || wr_bits || wr_status;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      wa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= dm_pkg::RESP_OKAY;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      if (aw_take) wa_ff <= s_axi_awaddr;
      if (w_take) wd_ff <= s_axi_wdata;
      if (w_take) ws_ff <= s_axi_wstrb;
      awready_ff <= !nxt_aw_full && !nxt_bvalid;
      wready_ff <= !nxt_w_full && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_do) bresp_ff <= wr_known ? dm_pkg::RESP_OKAY : dm_pkg::RESP_SLVERR;
    end
  end

  // Register storage; the status register ignores writes
  // Pointers reset unassigned
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      word_base_ff <= dm_pkg::BASE_NONE;
      bit_base_ff <= dm_pkg::BASE_NONE;
      dev_type_ff <= dm_pkg::WORD_RST;
      dev_num_ff <= dm_pkg::WORD_RST;
      saver_time_ff <= dm_pkg::WORD_RST;
      protect_dev_ff <= dm_pkg::WORD_RST;
      spare_word_ff <= dm_pkg::WORD_RST;
    end else begin
      if (wr_word_base) word_base_ff <= lane_merge(word_base_ff, wd_ff, ws_ff);
      if (wr_bit_base) bit_base_ff <= lane_merge(bit_base_ff, wd_ff, ws_ff);
      if (wr_type) dev_type_ff <= lane_merge(dev_type_ff, wd_ff, ws_ff);
      if (wr_num) dev_num_ff <= lane_merge(dev_num_ff, wd_ff, ws_ff);
      if (wr_saver) saver_time_ff <= lane_merge(saver_time_ff, wd_ff, ws_ff);
      if (wr_protect) protect_dev_ff <= lane_merge(protect_dev_ff, wd_ff, ws_ff);
      if (wr_spare) spare_word_ff <= lane_merge(spare_word_ff, wd_ff, ws_ff);
    end
  end

  wire word_blk_on = (word_base_ff != dm_pkg::BASE_NONE);
  wire bit_blk_on = (bit_base_ff != dm_pkg::BASE_NONE);

  wire [15:0] type_word = dev_type_ff;
  wire [15:0] num_word = dev_num_ff;

  wire type_ok = word_blk_on && (type_word >= 16'(dm_pkg::TYPE_MIN)) &&
                 (type_word <= 16'(dm_pkg::TYPE_MAX));
  wire func_en = type_ok;

  wire [3:0] type_code = type_ok ? type_word[3:0] : dm_pkg::TYPE_NONE;
  wire [15:0] type_max = type_ok ? dm_pkg::DEV_MAX[type_code] : '0;

  // Clamp to nearest limit; negative numbers take the minimum
  wire num_neg = num_word[15];
  wire [15:0] num_clamped = num_neg ? 16'h0000 : ((num_word > type_max) ? type_max : num_word);

  // Effective control bits; an unassigned bit block acts as all off to the hardware, though reads still show the stored bits
  wire eff_req = bit_blk_on && req_ff;
  wire eff_inhibit = bit_blk_on && inhibit_ff;
  wire eff_hex = bit_blk_on && hex_ff;

  // Bit block storage
  wire req_fall = req_prev_ff && !eff_req;
  wire in_spec = (scr_ff == dm_pkg::SCR_SPEC);
  // Completion events on the monitor screen
  wire done_set = bit_blk_on && in_spec && (done_hit || ok_hit || esc_hit);
  logic nxt_done;
  always_comb begin
    nxt_done = done_ff;
    // Clear by request drop or software
    if (req_fall) nxt_done = 1'b0;
    if (wr_bits && ws_ff[0]) nxt_done = wd_ff[dm_pkg::BIT_DONE];
    // Hardware set wins over any clear in the same cycle
    if (done_set) nxt_done = 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      req_ff <= 1'b0;
      done_ff <= 1'b0;
      inhibit_ff <= 1'b0;
      hex_ff <= 1'b0;
      req_prev_ff <= 1'b0;
      btn_mirror_ff <= '0;
    end else begin
      // Only live bits are stored; spare bits are dropped
      if (wr_bits && ws_ff[0]) req_ff <= wd_ff[dm_pkg::BIT_REQ];
      if (wr_bits && ws_ff[0]) inhibit_ff <= wd_ff[dm_pkg::BIT_INHIBIT];
      if (wr_bits && ws_ff[1]) hex_ff <= wd_ff[dm_pkg::BIT_HEX];
      done_ff <= nxt_done;
      req_prev_ff <= eff_req;
      btn_mirror_ff <= sync2_ff[3:0];
    end
  end

  // Screen saver timing
  logic saver_fire;
  logic [15:0] idle_min_ff;
  wire minute_tick;
  // Fixed ten minutes when the word block is unassigned
  wire [15:0] saver_limit = word_blk_on ? saver_time_ff : dm_pkg::SAVER_DEFAULT_MIN;
  wire saver_allowed = !eff_inhibit && (saver_limit != 16'h0000);
  assign saver_fire = saver_allowed && (idle_min_ff >= saver_limit);

  // Prescaler restarts on every press so idle time counts from the last touch
  dm_minute_tick #(
    .TICK_CYCLES(MINUTE_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .restart(any_press),
    .tick(minute_tick)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_min_ff <= '0;
    end else if (any_press || !saver_allowed) begin
      idle_min_ff <= '0;
    end else if (minute_tick && idle_min_ff != 16'hFFFF) begin
      idle_min_ff <= idle_min_ff + 16'h0001;
    end
  end

  // Screen sequencing
  always_comb begin
    nxt_scr = scr_ff;
    unique case (scr_ff)
      dm_pkg::SCR_TOP: begin
        // Valid type replaces the top screen
        if (func_en) nxt_scr = dm_pkg::SCR_SPEC;
        else if (ok_hit) nxt_scr = dm_pkg::SCR_MENU;
      end
      dm_pkg::SCR_SPEC: begin
        if (!func_en) nxt_scr = dm_pkg::SCR_TOP;
        else if (esc_hit) nxt_scr = dm_pkg::SCR_MENU;
      end
      dm_pkg::SCR_MENU: begin
        if (esc_hit) nxt_scr = dm_pkg::SCR_TOP;
      end
      dm_pkg::SCR_SAVER: begin
        if (any_press) nxt_scr = dm_pkg::SCR_TOP;
      end
    endcase
    if (scr_ff != dm_pkg::SCR_SAVER && saver_fire && !any_press) nxt_scr = dm_pkg::SCR_SAVER;
  end

  // Panel-facing outputs, all registered
  logic [3:0] shown_type_ff;
  logic [15:0] shown_num_ff;
  logic edit_en_ff;
  logic hex_out_ff;
  logic marker_ff;
  logic saver_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scr_ff <= dm_pkg::SCR_TOP;
      saver_ff <= 1'b0;
      shown_ff <= 1'b0;
      shown_type_ff <= dm_pkg::TYPE_NONE;
      shown_num_ff <= '0;
      edit_en_ff <= 1'b0;
      hex_out_ff <= 1'b0;
      marker_ff <= 1'b0;
    end else begin
      scr_ff <= nxt_scr;
      saver_ff <= (nxt_scr == dm_pkg::SCR_SAVER);
      shown_ff <= (nxt_scr == dm_pkg::SCR_SPEC);
      shown_type_ff <= type_code;
      shown_num_ff <= num_clamped;
      // Edit only with the request bit
      edit_en_ff <= (nxt_scr == dm_pkg::SCR_SPEC) && eff_req;
      hex_out_ff <= eff_hex;
      marker_ff <= (nxt_scr == dm_pkg::SCR_SPEC);
    end
  end

  // Read view of the bit block
  logic [15:0] bits_view;
  always_comb begin
    bits_view = '0;
    bits_view[dm_pkg::BIT_REQ] = req_ff;
    bits_view[dm_pkg::BIT_DONE] = done_ff;
    bits_view[dm_pkg::BIT_INHIBIT] = inhibit_ff;
    bits_view[dm_pkg::BIT_ESC] = btn_mirror_ff[0];
    bits_view[dm_pkg::BIT_MINUS] = btn_mirror_ff[1];
    bits_view[dm_pkg::BIT_PLUS] = btn_mirror_ff[2];
    bits_view[dm_pkg::BIT_OK] = btn_mirror_ff[3];
    bits_view[dm_pkg::BIT_HEX] = hex_ff;
    bits_view[dm_pkg::BIT_SHOWN] = shown_ff;
  end

  logic [31:0] status_view;
  always_comb begin
    status_view = '0;
    status_view[dm_pkg::ST_TYPE_LSB +: 4] = shown_type_ff;
    status_view[dm_pkg::ST_SCREEN_LSB +: 2] = scr_ff;
    status_view[dm_pkg::ST_FUNC_EN] = func_en;
    status_view[dm_pkg::ST_NUM_LSB +: 16] = shown_num_ff;
  end

  // Read channel
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [ADDR_W-1:0] ra = s_axi_araddr;
  wire rd_word_base = hit(ra, dm_pkg::ADDR_WORD_BASE);
  wire rd_bit_base = hit(ra, dm_pkg::ADDR_BIT_BASE);
  wire rd_type = hit(ra, dm_pkg::ADDR_DEV_TYPE);
  wire rd_num = hit(ra, dm_pkg::ADDR_DEV_NUM);
  wire rd_saver = hit(ra, dm_pkg::ADDR_SAVER_TIME);
  wire rd_protect = hit(ra, dm_pkg::ADDR_PROTECT_DEV);
  wire rd_spare = hit(ra, dm_pkg::ADDR_SPARE_WORD);
  wire rd_bits = hit(ra, dm_pkg::ADDR_CTL_BITS);
  wire rd_status = hit(ra, dm_pkg::ADDR_STATUS);
  wire rd_known = rd_word_base || rd_bit_base || rd_type || rd_num || rd_saver ||
                  rd_protect || rd_spare || rd_bits || rd_status;
  wire [15:0] rd_half = rd_word_base ? word_base_ff :
                        rd_bit_base ? bit_base_ff :
                        rd_type ? dev_type_ff :
                        rd_num ? dev_num_ff :
                        rd_saver ? saver_time_ff :
                        rd_protect ? protect_dev_ff :
                        rd_spare ? spare_word_ff :
                        rd_bits ? bits_view : 16'h0000;
  wire [31:0] rd_word = rd_status ? status_view : {16'h0000, rd_half};

  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= dm_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_known ? dm_pkg::RESP_OKAY : dm_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign screen_sel = scr_ff;
  assign shown_type = shown_type_ff;
  assign shown_num = shown_num_ff;
  assign edit_enable = edit_en_ff;
  assign hex_format = hex_out_ff;
  assign spec_marker = marker_ff;
  assign saver_on = saver_ff;
endmodule : dm_sysinfo
`default_nettype wire

//--- sim/dm_panel_model.sv
// Operator panel model: buttons and editor completion
`default_nettype none
module dm_panel_model (
  // Clock
  input wire logic mclk,
  // Requests: esc, minus, plus, ok, test done
  input wire logic [4:0] keys,
  // Panel lines
  output logic btn_esc,
  output logic btn_minus,
  output logic btn_plus,
  output logic btn_ok,
  output logic test_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {btn_esc, btn_minus, btn_plus, btn_ok, test_done} = 5'h00;
  always @(posedge mclk) begin
    {btn_esc, btn_minus, btn_plus, btn_ok, test_done} <= keys;
  end
endmodule : dm_panel_model
`default_nettype wire

//--- sim/dm_sysinfo_sva.sv
// Port checker for the system-information block
`default_nettype none
module dm_sysinfo_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Screen outputs
  input wire logic [1:0] screen_sel,
  input wire logic [3:0] shown_type,
  input wire logic edit_enable,
  input wire logic spec_marker,
  input wire logic saver_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_type_range: assert property (shown_type <= dm_pkg::TYPE_MAX)
    else $error("shown type out of range");
  chk_spec_valid: assert property (screen_sel == 2'd1 |-> shown_type >= dm_pkg::TYPE_MIN)
    else $error("monitor screen with bad type");
  chk_edit_spec: assert property (edit_enable |-> screen_sel == 2'd1 || $past(screen_sel) == 2'd1)
    else $error("editing outside monitor screen");
  chk_marker_screen: assert property (spec_marker == (screen_sel == 2'd1))
    else $error("marker and screen disagree");
  chk_saver_screen: assert property (saver_on == (screen_sel == 2'd3))
    else $error("saver flag and screen disagree");
endmodule : dm_sysinfo_chk
bind dm_sysinfo dm_sysinfo_chk u_chk (.mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .screen_sel, .shown_type, .edit_enable, .spec_marker, .saver_on);
`default_nettype wire

//--- sim/tb_display_monitor_sysinfo_link.sv
// Self-checking bench for the system-information block
`default_nettype none
module tb_display_monitor_sysinfo_link;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
  logic [3:0] s_axi_wstrb, shown_type;
  logic [1:0] s_axi_bresp, s_axi_rresp, screen_sel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, edit_enable, hex_format;
  logic btn_esc, btn_minus, btn_plus, btn_ok, test_done, spec_marker, saver_on;
  logic [15:0] shown_num;
  logic [4:0] keys;
  int n_fail = 0;
  int n_checks = 0;
  int tl[$] = '{0, 11, 15, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};

  dm_sysinfo #(.ADDR_W(8), .MINUTE_CYCLES(20)) dut_u (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .btn_esc, .btn_minus, .btn_plus, .btn_ok, .test_done, .screen_sel, .shown_type,
    .shown_num, .edit_enable, .hex_format, .spec_marker, .saver_on);
  dm_panel_model u_panel (.mclk, .keys, .btn_esc, .btn_minus, .btn_plus, .btn_ok, .test_done);

  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Negative numbers go to zero, large ones to the type's top
  function automatic logic [15:0] clamp(input int t, input logic [15:0] v);
    if (v[15]) return 16'h0000;
    return (v > dm_pkg::DEV_MAX[t]) ? dm_pkg::DEV_MAX[t] : v;
  endfunction : clamp

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    bit ad;
    bit wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) ad = 1'b1;
      if (s_axi_wready) wd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end while (!(ad && wd) && n < 99);
    do begin
      @(posedge mclk);
      n++;
    end while (!s_axi_bvalid && n < 99);
    chk(32'({s_axi_bresp, n >= 99}), 32'({er, 1'b0}));
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!s_axi_arready && n < 99);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (!s_axi_rvalid && n < 99);
    v = s_axi_rdata;
    chk(32'({s_axi_rresp, n >= 99}), 32'({er, 1'b0}));
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic press(input logic [4:0] k);
    @(posedge mclk);
    keys <= k;
    repeat (6) @(posedge mclk);
    keys <= 5'h00;
    repeat (6) @(posedge mclk);
  endtask : press

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, keys} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wstrb = 4'hF;
    seed = 32'h0000_FF41;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(dm_pkg::ADDR_WORD_BASE, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_FFFF);
    rd(dm_pkg::ADDR_BIT_BASE, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_FFFF);
    rd(8'h24, d, dm_pkg::RESP_SLVERR);
    wr(8'h24, 32'h0000_1234, dm_pkg::RESP_SLVERR);
    $display("reset and map test done");
    wr(dm_pkg::ADDR_WORD_BASE, 32'h0000_0032, dm_pkg::RESP_OKAY);
    wr(dm_pkg::ADDR_BIT_BASE, 32'h0000_0032, dm_pkg::RESP_OKAY);
    foreach (tl[i]) begin
      seed = xs(seed);
      wr(dm_pkg::ADDR_DEV_TYPE, 32'(tl[i]), dm_pkg::RESP_OKAY);
      wr(dm_pkg::ADDR_DEV_NUM, {16'h0000, seed[15:0]}, dm_pkg::RESP_OKAY);
      repeat (3) @(posedge mclk);
      rd(dm_pkg::ADDR_STATUS, d, dm_pkg::RESP_OKAY);
      if (tl[i] >= 1 && tl[i] <= 10) chk(d, {clamp(tl[i], seed[15:0]), 9'h000, 3'b101, 4'(tl[i])});
      else chk(d & 32'h0000_007F, 32'h0000_0000);
    end
    chk({shown_num, 12'h000, shown_type}, {clamp(10, seed[15:0]), 12'h000, 4'hA});
    chk(32'(spec_marker), 32'h0000_0001);
    rd(dm_pkg::ADDR_CTL_BITS, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_0200);
    $display("type decode test done");
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_0001, dm_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    chk(32'(edit_enable), 32'h0000_0001);
    press(5'h01);
    rd(dm_pkg::ADDR_CTL_BITS, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_0203);
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_0000, dm_pkg::RESP_OKAY);
    rd(dm_pkg::ADDR_CTL_BITS, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_0200);
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_0100, dm_pkg::RESP_OKAY);
    @(posedge mclk);
    keys <= 5'h0C;
    repeat (6) @(posedge mclk);
    rd(dm_pkg::ADDR_CTL_BITS, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_0360);
    chk(32'(hex_format), 32'h0000_0001);
    keys <= 5'h00;
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_0000, dm_pkg::RESP_OKAY);
    $display("edit and button test done");
    press(5'h10);
    chk(32'(screen_sel), 32'h0000_0002);
    rd(dm_pkg::ADDR_CTL_BITS, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_0002);
    press(5'h10);
    chk(32'(screen_sel), 32'h0000_0001);
    seed = xs(seed);
    wr(dm_pkg::ADDR_SPARE_WORD, seed, dm_pkg::RESP_OKAY);
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_7C08, dm_pkg::RESP_OKAY);
    rd(dm_pkg::ADDR_CTL_BITS, d, dm_pkg::RESP_OKAY);
    chk(d, 32'h0000_0200);
    $display("escape test done");
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_0004, dm_pkg::RESP_OKAY);
    wr(dm_pkg::ADDR_WORD_BASE, 32'h0000_FFFF, dm_pkg::RESP_OKAY);
    repeat (260) @(posedge mclk);
    chk(32'(saver_on), 32'h0000_0000);
    wr(dm_pkg::ADDR_CTL_BITS, 32'h0000_0000, dm_pkg::RESP_OKAY);
    repeat (230) @(posedge mclk);
    chk(32'(saver_on), 32'h0000_0001);
    press(5'h02);
    chk(32'(screen_sel), 32'h0000_0000);
    $display("saver test done");
    give_verdict();
  end
endmodule : tb_display_monitor_sysinfo_link
`default_nettype wire
